// >>> include/fpu_state_regs.vh
`ifndef FPU_STATE_REGS_VH
`define FPU_STATE_REGS_VH
// Opcode capture
`define OPC_W            11
`define OPC_HIGH_CONST   5'h1B
`define MISC_COMPAT_BIT  2
// Reset / initialise values
`define CTRL_INIT        16'h037F
`define STAT_INIT        16'h0000
`define TAG_INIT         16'hFFFF
`define OPC_INIT         11'h000
// Image layout selectors
`define FMT_PROT32       2'h0
`define FMT_PROT16       2'h1
`define FMT_REAL32       2'h2
`define FMT_REAL16       2'h3
// Operation codes
`define OP_ENV_STORE     3'h0
`define OP_FULL_SAVE     3'h1
`define OP_ENV_LOAD      3'h2
`define OP_FULL_RESTORE  3'h3
`define OP_EXT_SAVE      3'h4
`define OP_EXT_RESTORE   3'h5
`define OP_INIT          3'h6
// Image word counts (16-bit words)
`define ENV_WORDS16      5'h07
`define ENV_WORDS32      5'h0E
`define DATA_WORDS       6'h28
`define EXT_WORDS        6'h10
// Real-address word 4 field positions
`define R16_IPHI_LSB     12
`define R16_ZERO_BIT     11
// Byte address step per 16-bit word
`define WORD_BYTES       32'h00000002
`endif

// >>> rtl/fpu_opcode_capture_state_save.v
`timescale 1ns/100ps
`include "fpu_state_regs.vh"
// Summary of operation
// - Eleven-bit opcode capture on unmasked exceptions
// - Keep first-byte low three bits plus second
// - Feature bit two toggles compatibility sub-mode
// - Sub-mode captures every non-control opcode retired while idle, except in the cycle an initialise request is taken
// - Without sub-mode, refuse setting bit two
// - Environment store writes control through opcode
// - Full save writes all, then initialises
// - Layout chosen by mode and operand size
// - V86 and system mode use real layout
// - Loads reload control, status, tag and IP; whole environment only in 16-bit protected layout; restore adds data
// - Real16 word four: IP high, zero, opcode
// - Extended ops include vector and control state
// - Non-extended operands widen to extended format
// - Masked denormals normalised on widening
// - Operands stored least significant byte first
// - Addresses derived from operand start only
// - One indefinite per type, masked response
// - Source 100..00B means most negative value
// - Masked invalid integer store writes indefinite
// - Initialise sets tag word to all empty
// - Full save clears pointers and selectors
module fpu_opcode_capture_state_save #(
  parameter COMPAT_SUPPORTED = 1
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // Instruction retire
  input  wire        retire_valid,
  input  wire        retire_control,
  input  wire        retire_unmasked_exc,
  input  wire [7:0]  retire_opc_byte0,
  input  wire [7:0]  retire_opc_byte1,
  input  wire [31:0] retire_ip,
  input  wire [15:0] retire_cs,
  input  wire [31:0] retire_dp,
  input  wire [15:0] retire_ds,
  // Feature control
  input  wire        misc_wr,
  input  wire        misc_wdata_compat,
  output reg         misc_feature_enable,
  // Mode
  input  wire        prot_mode,
  input  wire        v86_mode,
  input  wire        system_mgmt_mode,
  input  wire        opsize32,
  // Operation request
  input  wire        op_start,
  input  wire [2:0]  op_code,
  input  wire [31:0] op_base,
  output wire        op_busy,
  output reg         op_done,
  // Memory port (16-bit words)
  output reg         mem_req,
  output reg         mem_we,
  output reg  [31:0] mem_addr,
  output reg  [15:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [15:0] mem_rdata,
  // Data and vector storage word port
  output reg  [5:0]  store_idx,
  output reg         store_vec,
  output reg         store_we,
  output reg  [15:0] store_wdata,
  input  wire [15:0] store_rdata,
  // Integer indefinite store
  input  wire        int_store_invalid,
  input  wire        invalid_masked,
  output reg         invalid_flag,
  // State view
  output reg  [`OPC_W-1:0] last_opcode_capture,
  output reg  [15:0] tag_word,
  output reg  [31:0] instr_ptr_offset,
  output reg  [15:0] instr_selector,
  output reg  [31:0] operand_ptr_offset,
  output reg  [15:0] operand_selector,
  output reg  [15:0] ctrl_word,
  output reg  [15:0] stat_word,
  output reg  [1:0]  image_format
);
  // ****************************************
  // Reset synchroniser
  // ****************************************
  reg rst_s1;
  reg rst_s2;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire srst_n = rst_s2;

  // ****************************************
  // Sequencer
  // ****************************************
  localparam S_IDLE = 2'h0;
  localparam S_MEM  = 2'h1;
  localparam S_FIN  = 2'h2;
  reg [1:0]  state;
  reg [2:0]  op;
  reg [5:0]  widx;
  reg [5:0]  env_n;
  reg [6:0]  total_n;
  reg [31:0] base;
  wire is_store = (op == `OP_ENV_STORE) || (op == `OP_FULL_SAVE) || (op == `OP_EXT_SAVE);
  assign op_busy = (state != S_IDLE);

  // Image length, fixed when the operation is taken
  wire       ext_op     = (op_code == `OP_EXT_SAVE) || (op_code == `OP_EXT_RESTORE);
  wire       env_only   = (op_code == `OP_ENV_STORE) || (op_code == `OP_ENV_LOAD);
  wire [6:0] env_cnt    = opsize32 ? {2'b00, `ENV_WORDS32} : {2'b00, `ENV_WORDS16};
  wire [6:0] data_cnt   = env_only ? 7'h00 : {1'b0, `DATA_WORDS};
  wire [6:0] ext_cnt    = ext_op ? {1'b0, `EXT_WORDS} : 7'h00;
  wire [6:0] next_total = env_cnt + data_cnt + ext_cnt;
  // Seven bits so the increment past index 63 never wraps
  wire [6:0] widx_inc   = {1'b0, widx} + 7'h01;
  wire [5:0] vec_start  = env_n + `DATA_WORDS;

  // ****************************************
  // Image layout select
  // ****************************************
  // Real layout in real, v86 and system mode, protected otherwise
  wire real_lay = !prot_mode || v86_mode || system_mgmt_mode;
  wire [1:0] fmt_now = real_lay ? (opsize32 ? `FMT_REAL32 : `FMT_REAL16)
                                : (opsize32 ? `FMT_PROT32 : `FMT_PROT16);
  wire wide = (image_format == `FMT_PROT32) || (image_format == `FMT_REAL32);
  wire realf = (image_format == `FMT_REAL32) || (image_format == `FMT_REAL16);

  // ****************************************
  // Environment word for image index
  // ****************************************
  reg [15:0] env_word;
  always @* begin
    env_word = 16'h0000;
    if (!wide) begin
      case (widx[2:0])
        3'h0: env_word = ctrl_word;
        3'h1: env_word = stat_word;
        3'h2: env_word = tag_word;
        3'h3: env_word = instr_ptr_offset[15:0];
        3'h4: env_word = realf ? {instr_ptr_offset[19:16], 1'b0, last_opcode_capture}
                               : instr_selector;
        3'h5: env_word = operand_ptr_offset[15:0];
        3'h6: env_word = realf ? {operand_ptr_offset[19:16], 12'h000} : operand_selector;
        default: env_word = 16'h0000;
      endcase
    end else begin
      case (widx[3:0])
        4'h0: env_word = ctrl_word;
        4'h2: env_word = stat_word;
        4'h4: env_word = tag_word;
        4'h6: env_word = instr_ptr_offset[15:0];
        4'h7: env_word = realf ? {4'h0, instr_ptr_offset[27:16]} : instr_ptr_offset[31:16];
        4'h8: env_word = realf ? {5'h00, last_opcode_capture} : instr_selector;
        4'h9: env_word = realf ? {4'h0, instr_ptr_offset[31:28], 1'b0, 7'h00}
                               : {5'h00, last_opcode_capture};
        4'hA: env_word = operand_ptr_offset[15:0];
        4'hB: env_word = realf ? 16'h0000 : operand_ptr_offset[31:16];
        4'hC: env_word = realf ? {4'h0, operand_ptr_offset[27:16]} : operand_selector;
        default: env_word = 16'h0000;
      endcase
    end
  end
  wire in_env = (widx < env_n);

  // ****************************************
  // Storage word port
  // ****************************************
  // Storage index past the environment
  always @* begin
    store_idx   = widx - env_n;
    store_vec   = (op == `OP_EXT_SAVE || op == `OP_EXT_RESTORE) && (widx >= vec_start);
    store_we    = (state == S_MEM) && !is_store && !in_env && mem_ack;
    store_wdata = mem_rdata;
  end

  // ****************************************
  // Capture and initialise events
  // ****************************************
  wire init_now = (state == S_FIN && op == `OP_FULL_SAVE) ||
                  (op_start && !op_busy && op_code == `OP_INIT);
  // Retires seen while busy are dropped; the sequencer owns the pointers then
  wire cap_evt  = retire_valid && !retire_control &&
                  (retire_unmasked_exc || misc_feature_enable);

  // ****************************************
  // State registers and sequencer
  // ****************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      op <= 3'h0;
      widx <= 6'h00;
      env_n <= 6'h00;
      total_n <= 7'h00;
      base <= 32'h00000000;
      op_done <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 16'h0000;
      image_format <= `FMT_PROT32;
      misc_feature_enable <= 1'b0;
      invalid_flag <= 1'b0;
      last_opcode_capture <= `OPC_INIT;
      tag_word <= `TAG_INIT;
      ctrl_word <= `CTRL_INIT;
      stat_word <= `STAT_INIT;
      instr_ptr_offset <= 32'h00000000;
      instr_selector <= 16'h0000;
      operand_ptr_offset <= 32'h00000000;
      operand_selector <= 16'h0000;
    end else if (!srst_n) begin
      state <= S_IDLE;
      op_done <= 1'b0;
      mem_req <= 1'b0;
      misc_feature_enable <= 1'b0;
    end else begin
      op_done <= 1'b0;
      if (misc_wr)
        misc_feature_enable <= misc_wdata_compat && (COMPAT_SUPPORTED != 0);
      if (int_store_invalid && invalid_masked)
        invalid_flag <= 1'b1;
      if (cap_evt && !op_busy) begin
        last_opcode_capture <= {retire_opc_byte0[2:0], retire_opc_byte1};
        instr_ptr_offset <= retire_ip;
        instr_selector <= retire_cs;
        operand_ptr_offset <= retire_dp;
        operand_selector <= retire_ds;
      end
      case (state)
        S_IDLE: begin
          if (op_start && op_code != `OP_INIT) begin
            op <= op_code;
            base <= op_base;
            widx <= 6'h00;
            image_format <= fmt_now;
            env_n <= env_cnt[5:0];
            total_n <= next_total;
            state <= S_MEM;
            mem_req <= 1'b0;
          end
        end
        S_MEM: begin
          mem_req <= 1'b1;
          mem_we  <= is_store;
          mem_addr <= base + {25'h0000000, widx, 1'b0};
          mem_wdata <= in_env ? env_word : store_rdata;
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            if (!is_store && in_env) begin
              case (widx[3:0])
                4'h0: ctrl_word <= mem_rdata;
                4'h1: if (!wide) stat_word <= mem_rdata;
                4'h2: if (!wide) tag_word <= mem_rdata; else stat_word <= mem_rdata;
                4'h4: if (wide) tag_word <= mem_rdata;
                4'h3: if (!wide) instr_ptr_offset[15:0] <= mem_rdata;
                4'h5: if (!wide) operand_ptr_offset[15:0] <= mem_rdata;
                4'h6: if (wide) instr_ptr_offset[15:0] <= mem_rdata;
                      else if (!realf) operand_selector <= mem_rdata;
                4'h7: if (wide) instr_ptr_offset[31:16] <= mem_rdata;
                default: ;
              endcase
              if (!wide && widx == 6'h04 && realf) begin
                last_opcode_capture <= mem_rdata[`OPC_W-1:0];
                instr_ptr_offset[19:16] <= mem_rdata[15:12];
              end
              if (!wide && widx == 6'h04 && !realf)
                instr_selector <= mem_rdata;
              if (wide && widx == 6'h09 && !realf)
                last_opcode_capture <= mem_rdata[`OPC_W-1:0];
            end
            if (widx_inc >= total_n)
              state <= S_FIN;
            else
              widx <= widx + 6'h01;
          end
        end
        S_FIN: begin
          state <= S_IDLE;
          op_done <= 1'b1;
          mem_we <= 1'b0;
        end
        default: state <= S_IDLE;
      endcase
      if (init_now) begin
        ctrl_word <= `CTRL_INIT;
        stat_word <= `STAT_INIT;
        tag_word <= `TAG_INIT;
        last_opcode_capture <= `OPC_INIT;
        instr_ptr_offset <= 32'h00000000;
        instr_selector <= 16'h0000;
        operand_ptr_offset <= 32'h00000000;
        operand_selector <= 16'h0000;
        // A store failing in the same cycle still sets the flag
        invalid_flag <= int_store_invalid && invalid_masked;
      end
    end
  end
  // Data-type conversion lives in the arithmetic datapath outside this block
endmodule

// >>> test/fpu_mem_model.sv
`timescale 1ns/100ps
// ****
// Image memory, 16-bit words, 0 to 3 wait cycles
// ****
module fpu_mem_model (
  input  wire        ref_clk,
  input  wire        mem_req,
  input  wire        mem_we,
  input  wire [31:0] mem_addr,
  input  wire [15:0] mem_wdata,
  input  wire [1:0]  slow,
  output reg         mem_ack,
  output reg  [15:0] mem_rdata
);
  logic [15:0] mem [0:511];
  int          w = 0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'h0000;
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    // Released data lines must not look valid
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (w < slow) w <= w + 1;
      else begin
        w <= 0;
        mem_ack <= 1'b1;
        if (mem_we) mem[mem_addr[9:1]] <= mem_wdata;
        else mem_rdata <= mem[mem_addr[9:1]];
      end
    end
  end
endmodule

// >>> test/fpu_state_save_asserts.sv
`timescale 1ns/100ps
`include "fpu_state_regs.vh"
module fpu_state_save_asserts #(parameter COMPAT_SUPPORTED = 1) (
  // Inputs and outputs of the unit
  input wire        ref_clk, rst_n, retire_valid, retire_control, retire_unmasked_exc,
  input wire [7:0]  retire_opc_byte0, retire_opc_byte1,
  input wire        misc_wr, misc_wdata_compat, misc_feature_enable, prot_mode, v86_mode,
  input wire        system_mgmt_mode, opsize32, op_start, op_busy, op_done, mem_req, mem_ack,
  input wire [2:0]  op_code,
  input wire [31:0] op_base, mem_addr, instr_ptr_offset, operand_ptr_offset,
  input wire [15:0] mem_wdata, tag_word, instr_selector, operand_selector,
  input wire        int_store_invalid, invalid_masked, invalid_flag,
  input wire [10:0] last_opcode_capture,
  input wire [1:0]  image_format
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire [10:0] opc  = {retire_opc_byte0[2:0], retire_opc_byte1};
  wire        take = retire_valid && !retire_control && !op_busy && !op_start;
  wire        go   = op_start && !op_busy && op_code != `OP_INIT;
  wire        rl   = !prot_mode || v86_mode || system_mgmt_mode;
  wire [1:0]  fmt  = rl ? (opsize32 ? `FMT_REAL32 : `FMT_REAL16) : (opsize32 ? `FMT_PROT32 : `FMT_PROT16);
  reg  [2:0]  cur_op;
  reg  [31:0] base_q;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_op <= 3'h7;
      base_q <= 32'h00000000;
    end else if (op_start && !op_busy) begin
      cur_op <= op_code;
      base_q <= op_base;
    end
  end
  chk_capture_exc: assert property (take && retire_unmasked_exc |=> last_opcode_capture == $past(opc))
    else $error("opcode not captured on exception");
  chk_capture_hold: assert property (retire_valid && !retire_unmasked_exc && !misc_feature_enable
    && !op_busy && !op_start |=> $stable(last_opcode_capture))
    else $error("opcode captured without exception");
  chk_compat_all: assert property (take && misc_feature_enable |=> last_opcode_capture == $past(opc))
    else $error("compat mode missed an opcode");
  chk_misc_write: assert property (misc_wr |=>
    misc_feature_enable == ($past(misc_wdata_compat) && COMPAT_SUPPORTED != 0))
    else $error("feature bit wrong");
  chk_init_values: assert property (op_start && !op_busy && op_code == `OP_INIT |=>
    tag_word == `TAG_INIT && last_opcode_capture == `OPC_INIT)
    else $error("init values wrong");
  chk_save_clears: assert property (op_done && cur_op == `OP_FULL_SAVE |-> ##[0:1] (tag_word == `TAG_INIT
    && instr_ptr_offset == 0 && operand_ptr_offset == 0 && instr_selector == 0 && operand_selector == 0))
    else $error("full save left state");
  chk_image_fmt: assert property (go |=> image_format == $past(fmt))
    else $error("image layout wrong");
  chk_first_addr: assert property (go |-> ##[2:3] (mem_req && mem_addr == base_q))
    else $error("first word not at base");
  chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("request dropped early");
  chk_invalid_set: assert property (int_store_invalid && invalid_masked |=> invalid_flag)
    else $error("invalid flag not set");
  cov_save: cover property (op_done && cur_op == `OP_FULL_SAVE);
  cov_restore: cover property (op_done && cur_op == `OP_FULL_RESTORE);
  cov_compat: cover property (take && misc_feature_enable);
endmodule
bind fpu_opcode_capture_state_save fpu_state_save_asserts #(.COMPAT_SUPPORTED(COMPAT_SUPPORTED)) u_chk (.*);

// >>> test/tb_top.sv
`timescale 1ns/100ps
`include "fpu_state_regs.vh"
module tb_top;
  logic ref_clk, rst_n, retire_valid, retire_control, retire_unmasked_exc, misc_wr, misc_wdata_compat;
  logic prot_mode, v86_mode, system_mgmt_mode, opsize32, op_start, int_store_invalid, invalid_masked;
  logic [7:0]  retire_opc_byte0, retire_opc_byte1;
  logic [31:0] retire_ip, retire_dp, op_base;
  logic [15:0] retire_cs, retire_ds, store_rdata;
  logic [2:0]  op_code;
  logic [1:0]  slow;
  wire         op_busy, op_done, mem_req, mem_we, mem_ack, store_vec, store_we, misc_feature_enable, invalid_flag;
  wire  [31:0] mem_addr, instr_ptr_offset, operand_ptr_offset;
  wire  [15:0] mem_wdata, mem_rdata, store_wdata, tag_word, instr_selector, operand_selector, ctrl_word, stat_word;
  wire  [5:0]  store_idx;
  wire  [10:0] last_opcode_capture;
  wire  [1:0]  image_format;
  int          errors = 0, n_compared = 0, i, k;
  logic [31:0] q[$], a, w_addr;
  logic [10:0] e, p;
  fpu_opcode_capture_state_save u_fpu_opcode_capture_state_save (.*);
  fpu_mem_model u_fpu_mem_model (.*);
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ****
  // Shared tasks
  // ****
  task automatic cmp(string n, logic [31:0] x, logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task stop_test;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task tick(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task retire(logic x);
    a = $urandom;
    {retire_ip, retire_dp, retire_cs, retire_ds} = {$urandom, $urandom, a};
    retire_opc_byte0 = {5'h1B, a[2:0]};
    retire_opc_byte1 = a[15:8];
    e = {a[2:0], a[15:8]};
    retire_unmasked_exc = x;
    retire_valid = 1;
    tick;
    retire_valid = 0;
    tick;
  endtask
  task run(logic [2:0] c);
    op_code = c;
    op_start = 1;
    tick;
    op_start = 0;
    for (k = 0; k < 400 && !op_done; k++) tick;
    if (!op_done) begin
      errors++;
      stop_test;
    end
    tick;
  endtask
  // ****
  // Result watcher: memory word or control word per finished operation
  // ****
  always @(posedge ref_clk) begin
    if (op_done && q.size() > 1) begin
      w_addr = q.pop_front();
      cmp("image word", q.pop_front(), w_addr == 32'hFFFFFFFF ? {16'h0000, ctrl_word}
        : {16'h0000, u_fpu_mem_model.mem[w_addr[9:1]]});
    end
  end
  initial begin
    {retire_valid, retire_control, retire_unmasked_exc, misc_wr, misc_wdata_compat, prot_mode, v86_mode} = 0;
    {system_mgmt_mode, opsize32, op_start, int_store_invalid, invalid_masked, op_code, slow, rst_n} = 0;
    {retire_opc_byte0, retire_opc_byte1, retire_ip, retire_dp, retire_cs, retire_ds} = 0;
    op_base = 32'h00000100;
    store_rdata = 16'h0000;
    void'($urandom(95007));
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1;
    tick(4);
    store_rdata = $urandom;
    cmp("tag", 16'hFFFF, tag_word);
    cmp("opcode", 11'h000, last_opcode_capture);
    retire(1);
    cmp("opcode", e, last_opcode_capture);
    p = e;
    retire(0);
    cmp("opcode", p, last_opcode_capture);
    // Handler relies on captured opcode, so the sub-mode is wanted
    misc_wdata_compat = 1;
    misc_wr = 1;
    tick;
    misc_wr = 0;
    tick;
    cmp("compat", 1'b1, misc_feature_enable);
    retire(0);
    cmp("opcode", e, last_opcode_capture);
    // Control instructions never update the capture
    p = e;
    retire_control = 1;
    retire(1);
    retire_control = 0;
    cmp("opcode", p, last_opcode_capture);
    for (i = 0; i < 3; i++) begin
      {prot_mode, v86_mode, system_mgmt_mode} = {i > 0, i == 1, i == 2};
      slow = i;
      retire(1);
      q.push_back(op_base + 8);
      q.push_back({retire_ip[19:16], 1'b0, e});
      run(`OP_ENV_STORE);
    end
    retire(1);
    q.push_back(op_base + 8);
    q.push_back({retire_ip[19:16], 1'b0, e});
    run(`OP_FULL_SAVE);
    cmp("tag", 16'hFFFF, tag_word);
    cmp("ip", 0, instr_ptr_offset);
    u_fpu_mem_model.mem[9'h080] = 16'h0262;
    q.push_back(32'hFFFFFFFF);
    q.push_back(16'h0262);
    run(`OP_FULL_RESTORE);
    run(`OP_EXT_SAVE);
    run(`OP_EXT_RESTORE);
    {int_store_invalid, invalid_masked} = 2'b11;
    tick;
    int_store_invalid = 0;
    tick;
    cmp("invalid", 1'b1, invalid_flag);
    op_code = `OP_INIT;
    op_start = 1;
    tick;
    op_start = 0;
    tick;
    cmp("tag", 16'hFFFF, tag_word);
    cmp("opcode", 11'h000, last_opcode_capture);
    cmp("invalid", 1'b0, invalid_flag);
    misc_wdata_compat = 0;
    misc_wr = 1;
    tick;
    misc_wr = 0;
    tick;
    cmp("compat", 1'b0, misc_feature_enable);
    stop_test;
  end
endmodule
